/* design/tc8_pkg.sv */
/*
 * Package for the 8-bit timer/counter: register offsets, field positions,
 * reset values and mode encodings.
 * Assumes an APB slave with 32-bit data, one register per aligned word.
 */
package tc8_pkg;
    // ============================================================
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL_A = 8'h00;
    localparam logic [7:0] OFF_CTRL_B = 8'h04;
    localparam logic [7:0] OFF_COUNT = 8'h08;
    localparam logic [7:0] OFF_CMP_A = 8'h0C;
    localparam logic [7:0] OFF_CMP_B = 8'h10;
    localparam logic [7:0] OFF_MASK = 8'h14;
    localparam logic [7:0] OFF_FLAG = 8'h18;
    localparam logic [7:0] OFF_POWER = 8'h1C;
    // ============================================================
    // Field positions
    localparam int CTRL_A_WGM_LO = 0;   // Bits 1:0 low mode bits
    localparam int CTRL_A_COMB_LO = 4;  // Bits 5:4 output B action
    localparam int CTRL_A_COMA_LO = 6;  // Bits 7:6 output A action
    localparam int CTRL_B_CS_LO = 0;    // Bits 2:0 clock select
    localparam int CTRL_B_WGM2 = 3;
    localparam int CTRL_B_FOCB = 6;
    localparam int CTRL_B_FOCA = 7;
    localparam int FLAG_OVF = 0;
    localparam int FLAG_CMPA = 1;
    localparam int FLAG_CMPB = 2;
    // ============================================================
    // Values
    localparam logic [7:0] BOTTOM_VAL = 8'h00;
    localparam logic [7:0] MAX_VAL = 8'hFF;
    localparam logic POWER_OFF_RESET = 1'b1;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;
    localparam logic [2:0] WGM_NORMAL = 3'h0;
    localparam logic [2:0] WGM_PC_MAX = 3'h1;
    localparam logic [2:0] WGM_CTC = 3'h2;
    localparam logic [2:0] WGM_FAST_MAX = 3'h3;
    localparam logic [2:0] WGM_PC_CMPA = 3'h5;
    localparam logic [2:0] WGM_FAST_CMPA = 3'h7;
    localparam logic [1:0] COM_NONE = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR = 2'h2;
    localparam logic [1:0] COM_SET = 2'h3;
endpackage : tc8_pkg

/* design/tick_if.sv */
/*
 * Interface carrying the timer tick and its source settings between the
 * clock-select unit and the counter core.
 * Assumes a single clock domain.
 */
`timescale 1ns/10ps
interface tick_if;
    logic [2:0] clock_select_field;
    logic enable;
    logic timer_tick;
    modport src (input clock_select_field, input enable, output timer_tick);
    modport snk (output clock_select_field, output enable, input timer_tick);
endinterface : tick_if

/* design/tick_select.sv */
/*
 * Clock-select unit: a prescaler and edge detector for the external pin,
 * producing a one-cycle timer_tick enable.
 * Assumes external_tick_pin is synchronous to core_clk.
 */
`timescale 1ns/10ps
module tick_select
    import tc8_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic external_tick_pin,
    tick_if.src tk
);
    logic [9:0] presc_q;
    logic pin_q;
    logic rise_w;
    logic fall_w;
    logic sel_w;

    function automatic logic is_wrap(input logic [9:0] cnt, input int bits);
        is_wrap = (cnt & 10'((1 << bits) - 1)) == 10'h0;
    endfunction : is_wrap

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            presc_q <= 10'h000;
            pin_q <= 1'b0;
        end else begin
            presc_q <= tk.enable ? presc_q + 10'h001 : 10'h000;
            pin_q <= external_tick_pin;
        end
    end

    assign rise_w = external_tick_pin & ~pin_q;
    assign fall_w = ~external_tick_pin & pin_q;

    // Divide ratios 1, 8, 64, 256, 1024 as in common practice
    always_comb begin
        unique case (tk.clock_select_field)
            3'h0: sel_w = 1'b0;                     // see R12
            3'h1: sel_w = 1'b1;
            3'h2: sel_w = is_wrap(presc_q, 3);
            3'h3: sel_w = is_wrap(presc_q, 6);
            3'h4: sel_w = is_wrap(presc_q, 8);
            3'h5: sel_w = is_wrap(presc_q, 10);
            3'h6: sel_w = fall_w;                   // see R10
            3'h7: sel_w = rise_w;
        endcase
    end

    assign tk.timer_tick = tk.enable & sel_w;      // see R11 see R6
endmodule : tick_select

/* design/timer8.sv */
/*
 * 8-bit timer/counter with two compare units and PWM, APB register slave.
 * Assumes one core clock, synchronous pin inputs, and an APB master that
 * holds each request until pready.
 */
// Added by the designer: register access over APB and the address map.
`timescale 1ns/10ps
// What this block does
// R1: Overflow, compare A, compare B interrupt flags
// R2: Two independent compare units, one counter
// R3: Bottom is count value 0x00
// R4: Maximum is count value 0xFF
// R5: Top is 0xFF or compare A
// R6: Runs only while power-off bit zero
// R7: Counter and compare registers 8 bits
// R8: All flags readable in one register
// R9: Each flag has own mask bit
// R10: Ticks from prescaler or external pin
// R11: Clock select picks source and edge
// R12: No source selected, counter stops
// R13: Three-bit clock select in control B
// R14: Compares run every cycle, every mode
// R15: Match sets compare flag
// R16: Matches drive two waveform outputs
// R17: Compare registers double buffered
// R18: Clear-on-match mode reloads counter
// R19: Phase-correct, fast PWM, frequency modes
// R20: Counter write beats clear and count
// R21: Match flag sets on next tick
// R22: Write one or service clears flag
// R23: Counter write blocks next tick's match
// R24: Normal mode increments, wraps, sets overflow
module timer8
    import tc8_pkg::*;
#(
    parameter int DATA_W = 8
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic external_tick_pin,
    input wire logic [2:0] irq_ack,
    output logic [2:0] irq_req,
    output logic wave_out_a,
    output logic wave_out_b
);
    // ============================================================
    // Registers
    logic [7:0] timer_control_a_q;
    logic [7:0] timer_control_b_q;
    logic [DATA_W-1:0] count_value_q;                                      // see R7
    logic [DATA_W-1:0] cmp_a_buf_q;
    logic [DATA_W-1:0] cmp_b_buf_q;
    logic [DATA_W-1:0] compare_a_value_q;
    logic [DATA_W-1:0] compare_b_value_q;
    logic [2:0] timer_mask_reg_q;
    logic [2:0] timer_flag_reg_q;
    logic [2:0] timer_flag_reg_d;
    logic timer_power_off_bit_q;
    logic dir_down_q;
    logic block_q;
    logic wave_a_q;
    logic wave_b_q;

    // ============================================================
    // Bus decode
    logic wr_w;
    logic rd_ok_w;
    logic wr_count_w;
    logic wr_cmp_a_w;
    logic wr_cmp_b_w;
    logic wr_flag_w;
    logic [7:0] wdata_w;
    logic [31:0] rdata_w;

    assign pready = 1'b1;
    assign wr_w = psel & penable & pwrite;
    assign wdata_w = pwdata[7:0];
    assign wr_count_w = wr_w & (paddr == OFF_COUNT);
    assign wr_cmp_a_w = wr_w & (paddr == OFF_CMP_A);
    assign wr_cmp_b_w = wr_w & (paddr == OFF_CMP_B);
    assign wr_flag_w = wr_w & (paddr == OFF_FLAG);
    assign rd_ok_w = (paddr <= OFF_POWER) & (paddr[1:0] == 2'b00);
    assign pslverr = psel & penable & ~rd_ok_w;

    always_comb begin
        rdata_w = 32'h0000_0000;
        unique case (paddr)
            OFF_CTRL_A: rdata_w[7:0] = timer_control_a_q;
            OFF_CTRL_B: rdata_w[7:0] = {2'b00, timer_control_b_q[5:0]};
            OFF_COUNT: rdata_w[7:0] = 8'(count_value_q);
            OFF_CMP_A: rdata_w[7:0] = 8'(cmp_a_buf_q);
            OFF_CMP_B: rdata_w[7:0] = 8'(cmp_b_buf_q);
            OFF_MASK: rdata_w[2:0] = timer_mask_reg_q;
            OFF_FLAG: rdata_w[2:0] = timer_flag_reg_q;       // see R8
            OFF_POWER: rdata_w[0] = timer_power_off_bit_q;
            default: rdata_w = 32'h0000_0000;
        endcase
    end
    assign prdata = rdata_w;

    // ============================================================
    // Mode decode
    logic [2:0] wgm_w;
    logic pwm_w;
    logic pc_w;
    logic top_cmpa_w;
    logic [DATA_W-1:0] top_w;
    logic at_top_w;
    logic at_bottom_w;
    logic at_max_w;
    logic tick_w;

    assign wgm_w = {timer_control_b_q[CTRL_B_WGM2], timer_control_a_q[CTRL_A_WGM_LO +: 2]};
    assign pc_w = (wgm_w == WGM_PC_MAX) | (wgm_w == WGM_PC_CMPA);          // see R19
    assign pwm_w = pc_w | (wgm_w == WGM_FAST_MAX) | (wgm_w == WGM_FAST_CMPA);
    assign top_cmpa_w = (wgm_w == WGM_CTC) | (wgm_w == WGM_PC_CMPA) | (wgm_w == WGM_FAST_CMPA);
    assign top_w = top_cmpa_w ? compare_a_value_q : DATA_W'(MAX_VAL);       // see R5
    assign at_bottom_w = count_value_q == DATA_W'(BOTTOM_VAL);              // see R3
    assign at_max_w = count_value_q == DATA_W'(MAX_VAL);                    // see R4
    assign at_top_w = count_value_q == top_w;

    tick_if tk ();
    assign tk.clock_select_field = timer_control_b_q[CTRL_B_CS_LO +: 3];   // see R13
    assign tk.enable = ~timer_power_off_bit_q;                             // see R6
    assign tick_w = tk.timer_tick;

    tick_select u_tick (
        .core_clk(core_clk),
        .rst(rst),
        .external_tick_pin(external_tick_pin),
        .tk(tk)
    );

    // ============================================================
    // Counter next value
    logic [DATA_W-1:0] count_d;
    logic dir_d;
    always_comb begin
        count_d = count_value_q;
        dir_d = dir_down_q;
        if (wr_count_w) begin
            count_d = DATA_W'(wdata_w);                                    // see R20
        end else if (tick_w) begin
            if (pc_w) begin
                if (at_top_w) dir_d = 1'b1;
                else if (at_bottom_w) dir_d = 1'b0;
                count_d = (dir_d) ? count_value_q - 1'b1 : count_value_q + 1'b1;
            end else if (at_top_w) begin
                count_d = DATA_W'(BOTTOM_VAL);                             // see R18
            end else begin
                count_d = count_value_q + 1'b1;                            // see R24
            end
        end
    end

    // Compare results are live every cycle; the flag follows at the tick
    logic eq_a_w;
    logic eq_b_w;
    assign eq_a_w = count_value_q == compare_a_value_q;                    // see R14 see R2
    assign eq_b_w = count_value_q == compare_b_value_q;

    logic ovf_w;
    logic set_a_w;
    logic set_b_w;
    assign ovf_w = tick_w & ~wr_count_w & (pc_w ? at_bottom_w : at_max_w); // see R24
    // A match standing between two ticks sets its flag at the closing tick,
    // unless a count write since the last tick has masked it
    assign set_a_w = tick_w & eq_a_w & ~block_q;                           // see R21 see R23
    assign set_b_w = tick_w & eq_b_w & ~block_q;

    // Hardware set wins over software or service clear
    assign timer_flag_reg_d = (timer_flag_reg_q
        & ~(wr_flag_w ? wdata_w[2:0] : 3'b000) & ~irq_ack)                // see R22
        | {set_b_w, set_a_w, ovf_w};                                       // see R15 see R1

    assign irq_req = timer_flag_reg_q & timer_mask_reg_q;                   // see R9

    logic upd_buf_w;
    assign upd_buf_w = ~pwm_w | (tick_w & (pc_w ? at_top_w : at_bottom_w)); // see R17

    // ============================================================
    // Waveform generation
    function automatic logic wave_next(input logic cur, input logic [1:0] com,
                                       input logic pwm, input logic pc,
                                       input logic hit, input logic down, input logic bot);
        wave_next = cur;
        if (!pwm) begin
            if (hit) begin
                unique case (com)
                    COM_NONE: wave_next = cur;
                    COM_TOGGLE: wave_next = ~cur;
                    COM_CLEAR: wave_next = 1'b0;
                    COM_SET: wave_next = 1'b1;
                endcase
            end
        end else if (com[1]) begin
            if (hit) wave_next = pc ? (down ~^ com[0]) : com[0];
            else if (bot & !pc) wave_next = ~com[0];
        end
    endfunction : wave_next

    logic hit_a_w;
    logic hit_b_w;
    assign hit_a_w = (set_a_w) | (wr_w & (paddr == OFF_CTRL_B) & wdata_w[CTRL_B_FOCA] & ~pwm_w);
    assign hit_b_w = (set_b_w) | (wr_w & (paddr == OFF_CTRL_B) & wdata_w[CTRL_B_FOCB] & ~pwm_w);

    // ============================================================
    // Register update
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            timer_control_a_q <= REG_RESET;
            timer_control_b_q <= REG_RESET;
            timer_mask_reg_q <= 3'b000;
            timer_power_off_bit_q <= POWER_OFF_RESET;
            cmp_a_buf_q <= '0;
            cmp_b_buf_q <= '0;
        end else if (wr_w) begin
            if (paddr == OFF_CTRL_A) timer_control_a_q <= wdata_w;
            if (paddr == OFF_CTRL_B) timer_control_b_q <= {2'b00, wdata_w[5:0]};
            if (paddr == OFF_MASK) timer_mask_reg_q <= wdata_w[2:0];
            if (paddr == OFF_POWER) timer_power_off_bit_q <= wdata_w[0];
            if (wr_cmp_a_w) cmp_a_buf_q <= DATA_W'(wdata_w);
            if (wr_cmp_b_w) cmp_b_buf_q <= DATA_W'(wdata_w);
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            count_value_q <= '0;
            dir_down_q <= 1'b0;
            timer_flag_reg_q <= 3'b000;
            compare_a_value_q <= '0;
            compare_b_value_q <= '0;
        end else begin
            count_value_q <= count_d;
            dir_down_q <= dir_d;
            timer_flag_reg_q <= timer_flag_reg_d;
            if (upd_buf_w) compare_a_value_q <= cmp_a_buf_q;
            if (upd_buf_w) compare_b_value_q <= cmp_b_buf_q;
        end
    end

    // The mask lives until the next tick, however long the timer stays
    // stopped, so a compare value equal to the written count stays quiet
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            block_q <= 1'b0;
        end else begin
            if (wr_count_w) block_q <= 1'b1;                               // see R23
            else if (tick_w) block_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wave_a_q <= 1'b0;
            wave_b_q <= 1'b0;
        end else begin
            wave_a_q <= wave_next(wave_a_q, timer_control_a_q[CTRL_A_COMA_LO +: 2],
                                  pwm_w, pc_w, hit_a_w, dir_down_q, tick_w & at_bottom_w);
            wave_b_q <= wave_next(wave_b_q, timer_control_a_q[CTRL_A_COMB_LO +: 2],
                                  pwm_w, pc_w, hit_b_w, dir_down_q, tick_w & at_bottom_w);
        end
    end
    assign wave_out_a = wave_a_q;                                          // see R16
    assign wave_out_b = wave_b_q;

    // ============================================================
    // Checks: counting and gating
    chk_stop_holds: assert property (@(posedge core_clk) disable iff (rst) // see R12
        (tk.clock_select_field == CS_STOP && !wr_count_w) |=> $stable(count_value_q))
        else $error("counter moved with no clock source");

    chk_stop_no_tick: assert property (@(posedge core_clk) disable iff (rst) // see R12
        tk.clock_select_field == CS_STOP |-> !tick_w)
        else $error("tick with no clock source");

    chk_write_wins: assert property (@(posedge core_clk) disable iff (rst) // see R20
        wr_count_w |=> count_value_q == DATA_W'($past(wdata_w)))
        else $error("counter write lost");

    chk_power_gate: assert property (@(posedge core_clk) disable iff (rst) // see R6
        timer_power_off_bit_q |-> !tick_w)
        else $error("tick while powered off");

    chk_normal_wrap: assert property (@(posedge core_clk) disable iff (rst) // see R24
        (wgm_w == WGM_NORMAL && tick_w && at_max_w && !wr_count_w)
        |=> count_value_q == '0 && timer_flag_reg_q[FLAG_OVF])
        else $error("normal wrap or overflow flag wrong");

    chk_ctc_clear: assert property (@(posedge core_clk) disable iff (rst) // see R18
        (wgm_w == WGM_CTC && tick_w && at_top_w && !wr_count_w) |=> count_value_q == '0)
        else $error("clear on match missing");

    chk_tick_rise: assert property (@(posedge core_clk) disable iff (rst) // see R11
        (tk.clock_select_field == CS_EXT_RISE && !timer_power_off_bit_q
         && external_tick_pin && !$past(external_tick_pin)) |-> tick_w)
        else $error("rising pin edge gave no tick");

    chk_tick_fall: assert property (@(posedge core_clk) disable iff (rst) // see R10
        (tk.clock_select_field == CS_EXT_FALL && !timer_power_off_bit_q
         && !external_tick_pin && $past(external_tick_pin)) |-> tick_w)
        else $error("falling pin edge gave no tick");

    chk_buf_direct: assert property (@(posedge core_clk) disable iff (rst) // see R17
        !pwm_w |=> compare_a_value_q == $past(cmp_a_buf_q))
        else $error("compare A not loaded from buffer");

    // ============================================================
    // Checks: compare flags and requests
    chk_flag_next: assert property (@(posedge core_clk) disable iff (rst) // see R21
        (tick_w && eq_a_w && !block_q) |=> timer_flag_reg_q[FLAG_CMPA])
        else $error("compare A flag not set");

    chk_flag_b_next: assert property (@(posedge core_clk) disable iff (rst) // see R15
        (tick_w && eq_b_w && !block_q) |=> timer_flag_reg_q[FLAG_CMPB])
        else $error("compare B flag not set");

    chk_flag_waits: assert property (@(posedge core_clk) disable iff (rst) // see R21
        (!tick_w && !timer_flag_reg_q[FLAG_CMPA]) |=> !timer_flag_reg_q[FLAG_CMPA])
        else $error("compare A flag set between ticks");

    chk_ctc_flag: assert property (@(posedge core_clk) disable iff (rst) // see R18
        (wgm_w == WGM_CTC && tick_w && at_top_w && !block_q) |=> timer_flag_reg_q[FLAG_CMPA])
        else $error("clear on match left flag low");

    chk_block_match: assert property (@(posedge core_clk) disable iff (rst) // see R23
        (tick_w && block_q && eq_a_w) |=> !$rose(timer_flag_reg_q[FLAG_CMPA]))
        else $error("match not blocked");

    chk_irq_mask: assert property (@(posedge core_clk) disable iff (rst) // see R9
        irq_req[FLAG_CMPB] == (timer_flag_reg_q[FLAG_CMPB] && timer_mask_reg_q[FLAG_CMPB]))
        else $error("mask gating wrong");

    chk_flag_clear: assert property (@(posedge core_clk) disable iff (rst) // see R22
        (wr_flag_w && wdata_w[FLAG_OVF] && !ovf_w) |=> !timer_flag_reg_q[FLAG_OVF])
        else $error("flag clear failed");
endmodule : timer8

/* dv/cpu_model.sv */
/*
 * CPU-side partner of the timer: an APB master with read and write tasks,
 * plus an interrupt-service strobe per source.
 * Assumes one rising-edge clock shared with the timer and a bench that
 * calls the tasks one at a time.
 */
`timescale 1ns/10ps
module cpu_model (
    input wire logic core_clk,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    input wire logic [2:0] irq_req,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    output logic [2:0] irq_ack
);
    logic last_err;

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        irq_ack = 3'h0;
        last_err = 1'b0;
    end

    // ============================================================
    // Bus cycle: setup, access held until pready, then release
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wr ? wd : ~wd;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    // Clearing a flag and the power bit are software duties
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] unused;
        xfer(1'b1, a, d, unused);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        xfer(1'b0, a, 32'h0000_0000, d);
    endtask : rd

    // Interrupt entry acknowledges one source for a single cycle
    task automatic service(input int idx);
        @(posedge core_clk);
        irq_ack <= 3'(1 << idx);
        @(posedge core_clk);
        irq_ack <= 3'h0;
    endtask : service
endmodule : cpu_model

/* dv/eight_bit_timer_counter_pwm_tb_top.sv */
/*
 * Self-checking bench for the 8-bit timer: register access, gating, counting,
 * compare flags, external ticks, clear-on-match and forced outputs.
 * Assumes the cpu_model partner and zero-wait APB answers.
 */
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module eight_bit_timer_counter_pwm_tb_top;
    import tc8_pkg::*;
    logic core_clk, rst, external_tick_pin;
    logic psel, penable, pwrite, pready, pslverr, wave_out_a, wave_out_b;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, d, c0;
    logic [2:0] irq_ack, irq_req;
    int err_count = 0;
    int n_compared = 0;
    int cyc = 0;
    logic [7:0] offs [6] = '{OFF_CTRL_A, OFF_CTRL_B, OFF_COUNT, OFF_CMP_A, OFF_CMP_B, OFF_MASK};

    timer8 dut_u (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .external_tick_pin(external_tick_pin), .irq_ack(irq_ack),
        .irq_req(irq_req), .wave_out_a(wave_out_a), .wave_out_b(wave_out_b));
    cpu_model cpu_u (.core_clk(core_clk), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .irq_req(irq_req), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .irq_ack(irq_ack));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // ============================================================
    // Helpers
    task automatic final_report;
        $display("Checks %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report

    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : settle

    // One full pulse on the pin, wide enough for the edge detector
    task automatic pulse;
        @(posedge core_clk);
        external_tick_pin <= 1'b1;
        repeat (4) @(posedge core_clk);
        external_tick_pin <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask : pulse

    // A hang anywhere ends the run as a failure
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            final_report();
        end
    end

    // ============================================================
    // Main sequence
    initial begin
        rst = 1'b1;
        external_tick_pin = 1'b0;
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        cpu_u.rd(OFF_POWER, d);
        `CHK("power_reset", 32'h0000_0001, d)
        foreach (offs[i]) begin
            cpu_u.rd(offs[i], d);
            `CHK("reg_reset", 32'h0000_0000, d)
        end
        cpu_u.rd(8'h20, d);
        `CHK("unmapped_err", 1'b1, cpu_u.last_err)
        // Gated while the power-off bit is set
        cpu_u.wr(OFF_CTRL_B, 32'h0000_0001);
        settle(20);
        cpu_u.rd(OFF_COUNT, d);
        `CHK("gated_count", 32'h0000_0000, d)
        cpu_u.wr(OFF_POWER, 32'h0000_0000);
        settle(20);
        cpu_u.rd(OFF_COUNT, d);
        `CHK("count_runs", 1'b1, d[7:0] != 8'h00)
        cpu_u.wr(OFF_CTRL_B, 32'(CS_STOP));
        cpu_u.rd(OFF_COUNT, c0);
        settle(20);
        cpu_u.rd(OFF_COUNT, d);
        `CHK("stopped_count", c0, d)
        // Normal mode: wrap and both compare matches
        cpu_u.wr(OFF_COUNT, 32'h0000_00F0);
        cpu_u.rd(OFF_COUNT, d);
        `CHK("count_write", 32'h0000_00F0, d)
        cpu_u.wr(OFF_CMP_A, 32'h0000_0010);
        cpu_u.wr(OFF_CMP_B, 32'h0000_0020);
        cpu_u.wr(OFF_MASK, 32'h0000_0005);
        cpu_u.wr(OFF_FLAG, 32'h0000_0007);
        cpu_u.wr(OFF_CTRL_B, 32'h0000_0001);
        settle(80);
        cpu_u.wr(OFF_CTRL_B, 32'(CS_STOP));
        cpu_u.rd(OFF_FLAG, d);
        `CHK("all_flags", 32'h0000_0007, d)
        settle(1);
        `CHK("masked_req", 3'h5, irq_req)
        cpu_u.wr(OFF_FLAG, 32'h0000_0001);
        cpu_u.rd(OFF_FLAG, d);
        `CHK("w1c_flag", 32'h0000_0006, d)
        settle(1);
        `CHK("req_after_clear", 3'h4, irq_req)
        cpu_u.service(FLAG_CMPB);
        cpu_u.rd(OFF_FLAG, d);
        `CHK("serviced_flag", 32'h0000_0002, d)
        // Rising pin edges; flag one tick after the match
        cpu_u.wr(OFF_FLAG, 32'h0000_0007);
        cpu_u.wr(OFF_COUNT, 32'h0000_0000);
        cpu_u.wr(OFF_CMP_A, 32'h0000_0002);
        cpu_u.wr(OFF_CTRL_B, 32'(CS_EXT_RISE));
        for (int i = 1; i <= 3; i++) begin
            pulse();
            cpu_u.rd(OFF_COUNT, d);
            `CHK("pin_rise_count", 32'(i), d)
            cpu_u.rd(OFF_FLAG, d);
            `CHK("flag_delay", (i == 3), d[FLAG_CMPA])
        end
        // A count write hides the match on the next tick
        cpu_u.wr(OFF_COUNT, 32'h0000_0002);
        cpu_u.wr(OFF_FLAG, 32'h0000_0007);
        pulse();
        pulse();
        cpu_u.rd(OFF_FLAG, d);
        `CHK("match_blocked", 1'b0, d[FLAG_CMPA])
        cpu_u.wr(OFF_CTRL_B, 32'(CS_EXT_FALL));
        cpu_u.rd(OFF_COUNT, c0);
        pulse();
        pulse();
        cpu_u.rd(OFF_COUNT, d);
        `CHK("pin_fall_count", c0 + 32'h0000_0002, d)
        // Clear on match keeps the count at or below compare A
        cpu_u.wr(OFF_CTRL_B, 32'(CS_STOP));
        cpu_u.wr(OFF_CTRL_A, 32'(WGM_CTC[1:0]));
        cpu_u.wr(OFF_COUNT, 32'h0000_0000);
        cpu_u.wr(OFF_CMP_A, 32'h0000_0005);
        cpu_u.wr(OFF_FLAG, 32'h0000_0007);
        cpu_u.wr(OFF_CTRL_B, 32'h0000_0001);
        settle(50);
        cpu_u.wr(OFF_CTRL_B, 32'(CS_STOP));
        cpu_u.rd(OFF_COUNT, d);
        `CHK("ctc_bound", 1'b1, d <= 32'h0000_0005)
        cpu_u.rd(OFF_FLAG, d);
        `CHK("ctc_flags", 32'h0000_0002, d)
        // Forced matches drive each output independently
        cpu_u.wr(OFF_CTRL_A, 32'(COM_SET) << CTRL_A_COMA_LO);
        cpu_u.wr(OFF_CTRL_B, 32'h0000_0001 << CTRL_B_FOCA);
        settle(3);
        `CHK("force_a_set", 1'b1, wave_out_a)
        `CHK("b_untouched", 1'b0, wave_out_b)
        cpu_u.wr(OFF_CTRL_A, 32'(COM_SET) << CTRL_A_COMB_LO);
        cpu_u.wr(OFF_CTRL_B, 32'h0000_0001 << CTRL_B_FOCB);
        settle(3);
        `CHK("force_b_set", 1'b1, wave_out_b)
        cpu_u.wr(OFF_CTRL_A, 32'(COM_CLEAR) << CTRL_A_COMA_LO);
        cpu_u.wr(OFF_CTRL_B, 32'h0000_0001 << CTRL_B_FOCA);
        settle(3);
        `CHK("force_a_clr", 1'b0, wave_out_a)
        // Divide by eight: 83 core edges hold ten or eleven ticks
        cpu_u.wr(OFF_COUNT, 32'h0000_0000);
        cpu_u.wr(OFF_CTRL_B, 32'h0000_0002);
        settle(80);
        cpu_u.wr(OFF_CTRL_B, 32'(CS_STOP));
        cpu_u.rd(OFF_COUNT, d);
        `CHK("presc_div8", 1'b1, d >= 32'h0000_000A && d <= 32'h0000_000B)
        final_report();
    end
endmodule : eight_bit_timer_counter_pwm_tb_top
